// ===== logic/host_pin_function_mux.sv
/*
 * pin-function multiplexer for the shared host pins, with an apb register slave.
 * assumes pin levels arrive asynchronous to core_clk and pads resolve the enables.
 */
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module hpm_host_pin_function_mux (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic masterReset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // internal function sources and the epp / dma engine
   input wire hpm_pkg::hpm_src_t src,
   input wire logic eppBusy,
   // shared pins, sampled levels
   input wire logic dackPinIn,
   input wire logic drqPinIn,
   input wire logic irq14PinIn,
   input wire logic irq15PinIn,
   input wire logic terminalCountPin,
   // shared pins, driven side
   output hpm_pkg::hpm_pad_t dackPad,
   output hpm_pkg::hpm_pad_t drqPad,
   output hpm_pkg::hpm_pad_t irq14Pad,
   output hpm_pkg::hpm_pad_t irq15Pad,
   output hpm_pkg::hpm_pad_t channelReadyPad,
   // decoded inputs handed to the functions
   output logic dmaAckN,
   output logic transferEnd,
   output logic gpioPort1Bit4In,
   output logic gpioPort1Bit5In,
   output logic gpioPort1Bit6In,
   output logic gpioPort1Bit7In,
   output logic kbcPort1Line4In,
   output logic kbcPort1Line5In,
   output logic refClockIs48,
   output logic eppMode
);
   import hpm_pkg::*;

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rstMeta;
   logic rstSync;
   logic mrMeta;
   logic mrSync;
   logic rst;

   // master reset is a pin: two flops before use
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
         mrMeta <= 1'b0;
         mrSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
         mrMeta <= masterReset;
         mrSync <= mrMeta;
      end
   end
   assign rst = !rstSync || mrSync;

   // ----------------------------------------
   // pin input synchronisers
   // ----------------------------------------
   logic [4:0] pinMeta;
   logic [4:0] pinSync;

   // reset to idle levels, so no false terminal count follows reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pinMeta <= HPM_PIN_SYNC_RESET;
         pinSync <= HPM_PIN_SYNC_RESET;
      end else begin
         pinMeta <= {terminalCountPin, irq15PinIn, irq14PinIn, drqPinIn, dackPinIn};
         pinSync <= pinMeta;
      end
   end

   // ----------------------------------------
   // registers and apb slave
   // ----------------------------------------
   logic [7:0] pinSelect;
   logic [7:0] globalCfg;
   logic [7:0] next_pinSelect;
   logic [7:0] next_globalCfg;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic setup;
   logic commit;
   logic mapped;
   logic [31:0] readWord;

   // no wait state: answer in the cycle after setup
   assign setup = psel && !penable && !pready;
   // a write lands only at the access edge that sees pready high
   assign commit = psel && penable && pready && pwrite;

   always_comb begin
      next_pinSelect = pinSelect;
      next_globalCfg = globalCfg;
      next_prdata = 32'h0000_0000;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      mapped = 1'b1;
      readWord = 32'h0000_0000;
      if (paddr == HPM_OFS_PIN_SELECT) begin
         readWord = {24'h00_0000, pinSelect};
         if (commit) next_pinSelect = pwdata[7:0];
      end else if (paddr == HPM_OFS_GLOBAL_CFG) begin
         readWord = {24'h00_0000, globalCfg};
         if (commit) next_globalCfg = pwdata[7:0];
      end else if (paddr == HPM_OFS_STATUS && !pwrite) begin
         // live pin levels after synchronising
         readWord = {27'h000_0000, pinSync};
      end else begin
         mapped = 1'b0;
      end
      if (setup) begin
         next_pready = 1'b1;
         next_prdata = readWord;
         next_pslverr = !mapped;
      end
   end

   // answer registered at the setup edge, registers at the access edge
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pinSelect <= HPM_PIN_SELECT_RESET;
         globalCfg <= HPM_GLOBAL_CFG_RESET;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (rst) begin
         pinSelect <= HPM_PIN_SELECT_RESET;
         globalCfg <= HPM_GLOBAL_CFG_RESET;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pinSelect <= next_pinSelect;
         globalCfg <= next_globalCfg;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------
   // pin routing
   // ----------------------------------------
   hpm_sel_t dackSel;
   hpm_sel_t drqSel;
   hpm_sel_t irq14Sel;
   hpm_sel_t irq15Sel;
   hpm_pad_t next_dackPad;
   hpm_pad_t next_drqPad;
   hpm_pad_t next_irq14Pad;
   hpm_pad_t next_irq15Pad;
   hpm_pad_t next_channelReadyPad;
   logic next_dmaAckN;
   logic next_transferEnd;
   logic [5:0] next_pinIn;

   assign dackSel = hpm_sel_t'(pinSelect[HPM_DACK_LSB +: 2]);
   assign drqSel = hpm_sel_t'(pinSelect[HPM_DRQ_LSB +: 2]);
   assign irq14Sel = hpm_sel_t'(pinSelect[HPM_IRQ14_LSB +: 2]);
   assign irq15Sel = hpm_sel_t'(pinSelect[HPM_IRQ15_LSB +: 2]);

   always_comb begin
      next_pinIn = 6'h00;
      next_dmaAckN = 1'b1;
      case (dackSel)
         HPM_SEL_GPIO: begin
            next_dackPad = '{out: src.gpioPort1Bit6Out, oe: src.gpioPort1Bit6Oe};
            next_pinIn[2] = pinSync[0];
         end
         HPM_SEL_KBC: begin
            next_dackPad = '{out: src.kbcPort1Line5Out, oe: src.kbcPort1Line5Oe};
            next_pinIn[5] = pinSync[0];
         end
         default: begin
            // 11 unlisted: keep the pin an input
            next_dackPad = '{out: 1'b1, oe: 1'b0};
            next_dmaAckN = pinSync[0];
         end
      endcase
      case (drqSel)
         HPM_SEL_GPIO: begin
            next_drqPad = '{out: src.gpioPort1Bit7Out, oe: src.gpioPort1Bit7Oe};
            next_pinIn[3] = pinSync[1];
         end
         HPM_SEL_KBC: begin
            next_drqPad = '{out: src.kbcPort1Line4Out, oe: src.kbcPort1Line4Oe};
            next_pinIn[4] = pinSync[1];
         end
         HPM_SEL_ALT: next_drqPad = '{out: src.systemControlInterruptN, oe: 1'b1};
         default: next_drqPad = '{out: src.dmaRequest, oe: 1'b1};
      endcase
      // irq14 pin routing, 11 falls to irq14
      case (irq14Sel)
         HPM_SEL_GPIO: begin
            next_irq14Pad = '{out: src.gpioPort1Bit4Out, oe: src.gpioPort1Bit4Oe};
            next_pinIn[0] = pinSync[2];
         end
         HPM_SEL_KBC: next_irq14Pad = '{out: src.powerLedOutput, oe: 1'b1};
         default: next_irq14Pad = '{out: src.irq14, oe: 1'b1};
      endcase
      // irq15 pin routing, 11 falls to irq15
      case (irq15Sel)
         HPM_SEL_GPIO: begin
            next_irq15Pad = '{out: src.gpioPort1Bit5Out, oe: src.gpioPort1Bit5Oe};
            next_pinIn[1] = pinSync[3];
         end
         HPM_SEL_KBC: next_irq15Pad = '{out: src.watchdogTimerOutput, oe: 1'b1};
         default: next_irq15Pad = '{out: src.irq15, oe: 1'b1};
      endcase
      // terminal count ends the transfer, only while the ack pin is ours
      next_transferEnd = pinSync[4] && (dackSel == HPM_SEL_DEFAULT || dackSel == HPM_SEL_ALT);
      // open drain: pull low to stretch only in epp mode
      next_channelReadyPad = '{out: 1'b0, oe: globalCfg[HPM_EPP_BIT] && eppBusy};
   end

   // every pin output from a flop; safe defaults are pins idle, not driving
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dackPad <= '{out: 1'b1, oe: 1'b0};
         drqPad <= '{out: 1'b0, oe: 1'b0};
         irq14Pad <= '{out: 1'b0, oe: 1'b0};
         irq15Pad <= '{out: 1'b0, oe: 1'b0};
         channelReadyPad <= '{out: 1'b0, oe: 1'b0};
         dmaAckN <= 1'b1;
         transferEnd <= 1'b0;
         {kbcPort1Line5In, kbcPort1Line4In, gpioPort1Bit7In, gpioPort1Bit6In,
            gpioPort1Bit5In, gpioPort1Bit4In} <= 6'h00;
         refClockIs48 <= 1'b0;
         eppMode <= 1'b0;
      end else begin
         dackPad <= next_dackPad;
         drqPad <= next_drqPad;
         irq14Pad <= next_irq14Pad;
         irq15Pad <= next_irq15Pad;
         channelReadyPad <= rst ? '{out: 1'b0, oe: 1'b0} : next_channelReadyPad;
         dmaAckN <= next_dmaAckN;
         transferEnd <= next_transferEnd;
         {kbcPort1Line5In, kbcPort1Line4In, gpioPort1Bit7In, gpioPort1Bit6In,
            gpioPort1Bit5In, gpioPort1Bit4In} <= next_pinIn;
         // 24 or 48 MHz reference select
         refClockIs48 <= globalCfg[HPM_CLK48_BIT];
         eppMode <= globalCfg[HPM_EPP_BIT];
      end
   end

endmodule : hpm_host_pin_function_mux

// ===== logic/hpm_pkg.sv
/*
 * constants, register map and carrier types for the host pin function mux.
 * assumes an apb master on core_clk and pin pads outside that resolve enables.
 */
package hpm_pkg;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] HPM_OFS_PIN_SELECT = 12'h000;
   localparam logic [11:0] HPM_OFS_GLOBAL_CFG = 12'h004;
   localparam logic [11:0] HPM_OFS_STATUS = 12'h008;

   localparam logic [7:0] HPM_PIN_SELECT_RESET = 8'h00;
   localparam logic [7:0] HPM_GLOBAL_CFG_RESET = 8'h00;
   // synchroniser reset {tc, irq15, irq14, drq, dack}: terminal count idles low
   localparam logic [4:0] HPM_PIN_SYNC_RESET = 5'h0f;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int HPM_IRQ14_LSB = 0;
   localparam int HPM_IRQ15_LSB = 2;
   localparam int HPM_DACK_LSB = 4;
   localparam int HPM_DRQ_LSB = 6;
   localparam int HPM_CLK48_BIT = 5;
   localparam int HPM_EPP_BIT = 0;

   // reference clock rates in MHz
   localparam int HPM_REF_LOW_MHZ = 24;
   localparam int HPM_REF_HIGH_MHZ = 48;

   typedef enum logic [1:0] {
      HPM_SEL_DEFAULT,
      HPM_SEL_GPIO,
      HPM_SEL_KBC,
      HPM_SEL_ALT
   } hpm_sel_t;

   // signals of one pad: level driven and its enable
   typedef struct packed {
      logic out;
      logic oe;
   } hpm_pad_t;

   // internal function sources offered to the shared pins
   typedef struct packed {
      logic dmaRequest;
      logic irq14;
      logic irq15;
      logic gpioPort1Bit4Out;
      logic gpioPort1Bit4Oe;
      logic gpioPort1Bit5Out;
      logic gpioPort1Bit5Oe;
      logic gpioPort1Bit6Out;
      logic gpioPort1Bit6Oe;
      logic gpioPort1Bit7Out;
      logic gpioPort1Bit7Oe;
      logic kbcPort1Line4Out;
      logic kbcPort1Line4Oe;
      logic kbcPort1Line5Out;
      logic kbcPort1Line5Oe;
      logic systemControlInterruptN;
      logic powerLedOutput;
      logic watchdogTimerOutput;
   } hpm_src_t;

endpackage : hpm_pkg

// ===== verif/hpm_host_model.sv
/*
 * host side of the shared pins: system bus and dma controller levels.
 * assumes the bench sets what the host drives when a pad is released.
 */
`timescale 1ns/1ns
module hpm_host_model (
   input wire hpm_pkg::hpm_pad_t dackPad,
   input wire hpm_pkg::hpm_pad_t drqPad,
   input wire hpm_pkg::hpm_pad_t irq14Pad,
   input wire hpm_pkg::hpm_pad_t irq15Pad,
   input wire logic [3:0] hostDrive,
   input wire logic tcAssert,
   output logic [3:0] pinLevel,
   output logic terminalCountPin
);
   import hpm_pkg::*;
   // wire level: an enabled pad wins, a released pin shows the host level
   assign pinLevel[0] = dackPad.oe ? dackPad.out : hostDrive[0];
   assign pinLevel[1] = drqPad.oe ? drqPad.out : hostDrive[1];
   assign pinLevel[2] = irq14Pad.oe ? irq14Pad.out : hostDrive[2];
   assign pinLevel[3] = irq15Pad.oe ? irq15Pad.out : hostDrive[3];
   assign terminalCountPin = tcAssert;
endmodule : hpm_host_model

// ===== verif/hpm_mux_asserts.sv
/*
 * port assertions for the host pin function mux.
 * assumes binding onto hpm_host_pin_function_mux with one clock domain.
 */
`timescale 1ns/1ns
module hpm_mux_asserts (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic masterReset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic eppBusy,
   input wire hpm_pkg::hpm_pad_t channelReadyPad,
   input wire logic refClockIs48,
   input wire logic eppMode
);
   import hpm_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   logic cfgWrite;
   logic [7:0] lastCfg;
   // accepted write to the global configuration word
   assign cfgWrite = psel && penable && pready && pwrite && !pslverr
      && paddr == HPM_OFS_GLOBAL_CFG;
   // keep the byte so the copy can be compared two edges later
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) lastCfg <= 8'h00;
      else if (cfgWrite) lastCfg <= pwdata[7:0];
   end
   // ----------------------------------------
   // apb answer
   // ----------------------------------------
   answer_one_cycle_a: assert property (psel && !penable |=> pready)
      else $error("setup without answer");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   error_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
   idle_data_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("data leak");
   // ----------------------------------------
   // configuration and channel ready
   // ----------------------------------------
   clock_select_copy_a: assert property (cfgWrite |=> ##1 refClockIs48 == lastCfg[5])
      else $error("clock select copy wrong");
   epp_mode_copy_a: assert property (cfgWrite |=> ##1 eppMode == lastCfg[0])
      else $error("epp mode copy wrong");
   ready_open_drain_a: assert property (channelReadyPad.out == 1'b0)
      else $error("channel ready driven high");
   no_stretch_off_a: assert property (!eppMode && $past(!eppMode) |-> !channelReadyPad.oe)
      else $error("stretch outside epp mode");
   stretch_on_busy_a: assert property ((eppMode && eppBusy) [*3] |-> channelReadyPad.oe)
      else $error("busy not stretched");
   master_reset_clears_a: assert property (masterReset [*5] |-> !refClockIs48 && !eppMode)
      else $error("master reset kept config");
   cover property (cfgWrite);
   cover property (pslverr);
   cover property (channelReadyPad.oe);
endmodule : hpm_mux_asserts

bind hpm_host_pin_function_mux hpm_mux_asserts chk_u (.core_clk, .reset_n, .masterReset,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .eppBusy,
   .channelReadyPad, .refClockIs48, .eppMode);

// ===== verif/test_host_pin_function_mux.sv
/*
 * self-checking bench for the host pin function mux.
 * assumes the host model on the pins and this bench as apb master.
 */
`timescale 1ns/1ns
module test_host_pin_function_mux;
   import hpm_pkg::*;
   logic core_clk = 0, reset_n = 0, masterReset = 0, psel = 0, penable = 0, pwrite = 0;
   logic eppBusy = 0, tcAssert = 0, pready, pslverr, dmaAckN, transferEnd;
   logic refClockIs48, eppMode, terminalCountPin, b4, b5, b6, b7, k4, k5;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] hostDrive = 4'h0, pinLevel, lv;
   hpm_src_t src = '0;
   hpm_pad_t dackPad, drqPad, irq14Pad, irq15Pad, channelReadyPad;
   hpm_pad_t d[4], i14[4], i15[4], dk[4];
   logic [32:0] expQ[$];
   int fail_count = 0, compares = 0, seed = 32'h986d;
   logic [1:0] v;
   hpm_host_pin_function_mux dut_u (.core_clk, .reset_n, .masterReset, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .src, .eppBusy,
      .dackPinIn(pinLevel[0]), .drqPinIn(pinLevel[1]), .irq14PinIn(pinLevel[2]),
      .irq15PinIn(pinLevel[3]), .terminalCountPin, .dackPad, .drqPad, .irq14Pad,
      .irq15Pad, .channelReadyPad, .dmaAckN, .transferEnd, .gpioPort1Bit4In(b4),
      .gpioPort1Bit5In(b5), .gpioPort1Bit6In(b6), .gpioPort1Bit7In(b7),
      .kbcPort1Line4In(k4), .kbcPort1Line5In(k5), .refClockIs48, .eppMode);
   hpm_host_model host_u (.dackPad, .drqPad, .irq14Pad, .irq15Pad, .hostDrive, .tcAssert,
      .pinLevel, .terminalCountPin);
   initial forever #2 core_clk = ~core_clk;
   // ----------------------------------------
   // checking and apb tasks
   // ----------------------------------------
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic stop_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   // the request stands until pready is seen; a hang ends at the watchdog
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
         input logic [32:0] exp);
      @(posedge core_clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      expQ.push_back(exp);
      @(posedge core_clk);
      penable <= 1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask : apb
   // answers are compared against the oldest note, writes on the error bit only
   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1) begin
         if (pwrite) chk({32'h0, pslverr}, {32'h0, expQ[0][32]});
         else chk({pslverr, prdata}, expQ[0]);
         void'(expQ.pop_front());
      end
   end
   task automatic settle;
      repeat (5) @(posedge core_clk);
      #1;
   endtask : settle
   initial begin
      #40000;
      fail_count++;
      stop_test();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1;
      repeat (4) @(posedge core_clk);
      for (int k = 0; k < 8; k++) begin
         v = k[1:0];
         @(posedge core_clk);
         src <= hpm_src_t'(18'($random(seed)));
         hostDrive <= 4'($random(seed));
         tcAssert <= 1'($random(seed));
         apb(1, HPM_OFS_PIN_SELECT, {24'h0, {4{v}}}, 33'h0);
         settle();
         d = '{{src.dmaRequest, 1'b1}, {src.gpioPort1Bit7Out, src.gpioPort1Bit7Oe},
            {src.kbcPort1Line4Out, src.kbcPort1Line4Oe}, {src.systemControlInterruptN, 1'b1}};
         i14 = '{{src.irq14, 1'b1}, {src.gpioPort1Bit4Out, src.gpioPort1Bit4Oe},
            {src.powerLedOutput, 1'b1}, {src.irq14, 1'b1}};
         i15 = '{{src.irq15, 1'b1}, {src.gpioPort1Bit5Out, src.gpioPort1Bit5Oe},
            {src.watchdogTimerOutput, 1'b1}, {src.irq15, 1'b1}};
         // acknowledge input: pad released with its level parked high
         dk = '{2'b10, {src.gpioPort1Bit6Out, src.gpioPort1Bit6Oe},
            {src.kbcPort1Line5Out, src.kbcPort1Line5Oe}, 2'b10};
         chk({31'h0, drqPad}, {31'h0, d[v]});
         chk({31'h0, irq14Pad}, {31'h0, i14[v]});
         chk({31'h0, irq15Pad}, {31'h0, i15[v]});
         chk({31'h0, dackPad}, {31'h0, dk[v]});
         lv[0] = dk[v].oe ? dk[v].out : hostDrive[0];
         lv[1] = d[v].oe ? d[v].out : hostDrive[1];
         lv[2] = i14[v].oe ? i14[v].out : hostDrive[2];
         lv[3] = i15[v].oe ? i15[v].out : hostDrive[3];
         chk({25'h0, b4, b5, b6, b7, k4, k5, dmaAckN, transferEnd}, {25'h0, v == 1 && lv[2],
            v == 1 && lv[3], v == 1 && lv[0], v == 1 && lv[1], v == 2 && lv[1],
            v == 2 && lv[0], v == 1 || v == 2 || lv[0], (v == 0 || v == 3) && tcAssert});
         apb(0, HPM_OFS_STATUS, 32'h0, {28'h0, tcAssert, lv});
         apb(0, HPM_OFS_PIN_SELECT, 32'h0, {25'h0, {4{v}}});
      end
      // refused: write to status, unmapped read, register left alone
      apb(1, HPM_OFS_STATUS, 32'hff, {1'b1, 32'h0});
      apb(0, 12'h00c, 32'h0, {1'b1, 32'h0});
      apb(0, HPM_OFS_PIN_SELECT, 32'h0, {25'h0, {4{v}}});
      for (int c = 0; c < 4; c++) begin
         apb(1, HPM_OFS_GLOBAL_CFG, {26'h0, c[1], 4'h0, c[0]}, 33'h0);
         apb(0, HPM_OFS_GLOBAL_CFG, 32'h0, {27'h0, c[1], 4'h0, c[0]});
         eppBusy <= 1;
         settle();
         chk({31'h0, refClockIs48, eppMode}, {31'h0, c[1], c[0]});
         chk({31'h0, channelReadyPad}, {31'h0, 1'b0, c[0]});
         @(posedge core_clk);
         eppBusy <= 0;
         settle();
         chk({31'h0, channelReadyPad}, 33'h0);
      end
      // master reset held high clears the registers
      apb(1, HPM_OFS_PIN_SELECT, 32'h55, 33'h0);
      masterReset <= 1;
      repeat (6) @(posedge core_clk);
      masterReset <= 0;
      repeat (4) @(posedge core_clk);
      apb(0, HPM_OFS_PIN_SELECT, 32'h0, 33'h0);
      apb(0, HPM_OFS_GLOBAL_CFG, 32'h0, 33'h0);
      settle();
      stop_test();
   end
endmodule : test_host_pin_function_mux
